/* File: lvdsf_framer.sv */
`timescale 1ns/1ps
`include "lvdsf_regs.svh"

module lvdsf_framer
  import lvdsf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic master_clock_in,
  input wire logic [9:0] pixel_in,
  input wire logic [9:0] slave_pixel_in,
  input wire logic row_valid,
  input wire logic image_valid,
  input wire logic stereo_mode,
  input wire logic use_10bit,
  input wire logic [1:0] column_binning,
  input wire logic serial_power_down,
  input wire logic serial_data_power_down,
  input wire logic shift_clock_power_down,
  input wire logic stereo_error_in,
  output logic [`LVDSF_PKT_W-1:0] serial_data_pins,
  output logic serial_data_oe,
  output logic serial_shift_clock_pins,
  output logic serial_shift_clock_oe,
  output logic pixel_clock_out,
  output logic stereo_fault_out
);

  logic mc_s1_q;
  logic mc_s2_q;
  logic mc_s3_q;
  logic pix_tick;
  logic fv1_q;
  logic lv1_q;
  logic fv2_q;
  logic lv2_q;
  logic [9:0] pix1_q;
  logic [9:0] spix1_q;
  logic [1:0] rep_q;
  logic [1:0] rep_last;
  logic [9:0] word_d;
  logic [9:0] word_q;
  logic [9:0] sword_d;
  logic [`LVDSF_PKT_W-1:0] pkt_d;

  // Master clock sampled through two flops, third flop finds the edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mc_s1_q <= 1'b0;
      mc_s2_q <= 1'b0;
      mc_s3_q <= 1'b0;
    end else if (ce) begin
      mc_s1_q <= master_clock_in;
      mc_s2_q <= mc_s1_q;
      mc_s3_q <= mc_s2_q;
    end
  end

  assign pix_tick = mc_s2_q & ~mc_s3_q;

  // Inverted, delayed pixel clock; it falls as the new word appears
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pixel_clock_out <= 1'b1;
    end else if (ce) begin
      pixel_clock_out <= ~mc_s2_q;
    end
  end

  // Repeat count per binning setting
  always_comb begin
    unique case (column_binning)
      LVDSF_BIN_X2: rep_last = `LVDSF_REP_LAST_X2;
      LVDSF_BIN_X4: rep_last = `LVDSF_REP_LAST_X4;
      default: rep_last = `LVDSF_REP_LAST_X1;
    endcase
  end

  // Repeat counter restarts at every row
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rep_q <= `LVDSF_REP_ZERO;
    end else if (ce && pix_tick) begin
      if (!row_valid || rep_q == rep_last) begin
        rep_q <= `LVDSF_REP_ZERO;
      end else begin
        rep_q <= rep_q + `LVDSF_REP_ONE;
      end
    end
  end

  // One-slot delay so a flag can precede a rising valid
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fv1_q <= 1'b0;
      lv1_q <= 1'b0;
      fv2_q <= 1'b0;
      lv2_q <= 1'b0;
      pix1_q <= 10'h000;
      spix1_q <= 10'h000;
    end else if (ce && pix_tick) begin
      fv1_q <= image_valid;
      lv1_q <= row_valid;
      fv2_q <= fv1_q;
      lv2_q <= lv1_q;
      // Held pixel is repeated while binning
      if (rep_q == `LVDSF_REP_ZERO) begin
        pix1_q <= pixel_in;
        spix1_q <= slave_pixel_in;
      end
    end
  end

  // Flag insertion and reserved value substitution
  always_comb begin
    if (!fv1_q && image_valid) begin
      word_d = `LVDSF_WORD_FS;
    end else if (!fv1_q && fv2_q) begin
      word_d = `LVDSF_WORD_FE;
    end else if (!lv1_q && row_valid) begin
      word_d = `LVDSF_WORD_LS;
    end else if (!lv1_q && lv2_q) begin
      word_d = `LVDSF_WORD_LE;
    end else if (pix1_q < `LVDSF_PIX_MIN) begin
      word_d = `LVDSF_PIX_MIN;
    end else begin
      word_d = pix1_q;
    end
    // Slave byte carries the same flags as the master
    if (word_d < `LVDSF_PIX_MIN) begin
      sword_d = word_d;
    end else if (spix1_q < `LVDSF_PIX_MIN) begin
      sword_d = `LVDSF_PIX_MIN;
    end else begin
      sword_d = spix1_q;
    end
  end

  // Packet layout, bit 0 leaves first
  always_comb begin
    pkt_d = '0;
    pkt_d[0] = `LVDSF_START_BIT;
    if (stereo_mode) begin
      pkt_d[`LVDSF_MST_MSB:`LVDSF_MST_LSB] = word_d[9:2];
      pkt_d[`LVDSF_SLV_MSB:`LVDSF_SLV_LSB] = sword_d[9:2];
      pkt_d[`LVDSF_STEREO_LEN-1] = `LVDSF_STOP_BIT;
    end else if (use_10bit) begin
      pkt_d[`LVDSF_W10_MSB:`LVDSF_MST_LSB] = word_d;
      pkt_d[`LVDSF_MONO_LEN-1] = `LVDSF_STOP_BIT;
    end else begin
      pkt_d[`LVDSF_MST_MSB:`LVDSF_MST_LSB] = word_d[9:2];
      pkt_d[`LVDSF_LV_BIT] = lv1_q;
      pkt_d[`LVDSF_FV_BIT] = fv1_q;
      pkt_d[`LVDSF_MONO_LEN-1] = `LVDSF_STOP_BIT;
    end
  end

  // Packet register, updated once per pixel slot
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_data_pins <= '0;
      word_q <= 10'h000;
    end else if (ce && pix_tick) begin
      serial_data_pins <= pkt_d;
      word_q <= word_d;
    end
  end

  // Output enables and stereo fault pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_data_oe <= 1'b0;
      serial_shift_clock_oe <= 1'b0;
      serial_shift_clock_pins <= 1'b0;
      stereo_fault_out <= 1'b0;
    end else if (ce) begin
      serial_data_oe <= ~serial_power_down;
      serial_shift_clock_oe <= ~serial_power_down &
                               ~shift_clock_power_down;
      serial_shift_clock_pins <= ~mc_s2_q;
      stereo_fault_out <= stereo_mode & stereo_error_in;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_FRAME_START: assert property (
    ce && pix_tick && !fv1_q && image_valid |=> word_q == `LVDSF_WORD_FS)
    else $error("frame start word missing");
  AST_FRAME_END: assert property (
    ce && pix_tick && !fv1_q && fv2_q && !image_valid
    |=> word_q == `LVDSF_WORD_FE)
    else $error("frame end word missing");
  AST_LINE_START: assert property (
    ce && pix_tick && fv1_q && image_valid && !lv1_q && row_valid
    |=> word_q == `LVDSF_WORD_LS)
    else $error("line start word missing");
  AST_LINE_END: assert property (
    ce && pix_tick && fv1_q && image_valid && !lv1_q && lv2_q && !row_valid
    |=> word_q == `LVDSF_WORD_LE)
    else $error("line end word missing");
  AST_NO_RESERVED_PIXEL: assert property (
    ce && pix_tick && fv1_q && lv1_q |=> word_q >= `LVDSF_PIX_MIN)
    else $error("reserved value sent as pixel");
  AST_BIN_REPEAT: assert property (
    ce && pix_tick && rep_q != `LVDSF_REP_ZERO |=> $stable(pix1_q))
    else $error("binned pixel not repeated");
  AST_BIN4_COUNT: assert property (
    ce && pix_tick && row_valid && column_binning == LVDSF_BIN_X4
    && rep_q == `LVDSF_REP_LAST_X4 |=> rep_q == `LVDSF_REP_ZERO)
    else $error("4x repeat count wrong");
  AST_DATA_OE: assert property (
    ce |=> serial_data_oe == !$past(serial_power_down))
    else $error("serial data enable wrong");
  AST_SCLK_OE: assert property (
    ce && (serial_power_down || shift_clock_power_down)
    |=> !serial_shift_clock_oe)
    else $error("shift clock driven while powered down");
  AST_FAULT_LOW: assert property (
    ce && !stereo_mode |=> !stereo_fault_out)
    else $error("fault pin high outside stereo mode");
  AST_PCLK_INV: assert property (
    ce && pix_tick |=> !pixel_clock_out)
    else $error("pixel clock not inverted");
  AST_FRAMING: assert property (
    ce && pix_tick && !stereo_mode
    |=> serial_data_pins[0] && !serial_data_pins[`LVDSF_MONO_LEN-1])
    else $error("packet start or stop bit wrong");

endmodule

/* File: lvdsf_pkg.sv */
package lvdsf_pkg;
  // Column binning setting, two-bit field
  typedef enum logic [1:0] {
    LVDSF_BIN_X1 = 2'h0,
    LVDSF_BIN_X2 = 2'h1,
    LVDSF_BIN_X4 = 2'h2
  } lvdsf_bin_type;
endpackage

/* File: lvdsf_regs.svh */
`ifndef LVDSF_REGS_SVH
`define LVDSF_REGS_SVH

// Reserved words embedded in the pixel stream
`define LVDSF_WORD_FS 10'h000
`define LVDSF_WORD_LS 10'h001
`define LVDSF_WORD_LE 10'h002
`define LVDSF_WORD_FE 10'h003
// Lowest real pixel value allowed on the wire
`define LVDSF_PIX_MIN 10'h004

// Packet framing bits
`define LVDSF_START_BIT 1'b1
`define LVDSF_STOP_BIT 1'b0
`define LVDSF_PKT_W 18
`define LVDSF_MONO_LEN 12
`define LVDSF_STEREO_LEN 18
// Payload field positions inside the packet
`define LVDSF_MST_MSB 8
`define LVDSF_MST_LSB 1
`define LVDSF_SLV_MSB 16
`define LVDSF_SLV_LSB 9
`define LVDSF_W10_MSB 10
`define LVDSF_LV_BIT 9
`define LVDSF_FV_BIT 10

// Repeat counts for column binning
`define LVDSF_REP_LAST_X1 2'h0
`define LVDSF_REP_LAST_X2 2'h1
`define LVDSF_REP_LAST_X4 2'h3
`define LVDSF_REP_ZERO 2'h0
`define LVDSF_REP_ONE 2'h1

`endif

/* File: lvdsf_rx.sv */
`timescale 1ns/1ps

module lvdsf_rx
  import lvdsf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [17:0] serial_data_pins,
  input wire logic serial_shift_clock_pins,
  input wire logic [1:0] column_binning,
  output logic [9:0] kept_word,
  output logic kept_valid
);
  logic sck_q;
  logic [1:0] cnt_q;
  // Shift clock rise marks a settled word; keep one per binning run
  always_ff @(posedge clk) begin
    sck_q <= serial_shift_clock_pins;
    kept_valid <= 1'b0;
    if (!rst_n) begin
      cnt_q <= 2'h0;
      kept_word <= 10'h000;
    end else if (serial_shift_clock_pins && !sck_q) begin
      cnt_q <= (column_binning == LVDSF_BIN_X4) ? cnt_q + 2'h1 :
        (column_binning == LVDSF_BIN_X2) ? {1'b0, ~cnt_q[0]} : 2'h0;
      if (cnt_q == 2'h0) begin
        kept_word <= serial_data_pins[10:1];
        kept_valid <= 1'b1;
      end
    end
  end
endmodule

/* File: tb.sv */
`timescale 1ns/1ps

module tb;
  import lvdsf_pkg::*;
  logic clk, rst_n, mck, rv, iv, stm, u10, pd, dpd, cpd, err;
  logic [9:0] pix, spix, kw;
  logic [1:0] bin;
  logic [17:0] dout;
  logic doe, sck, soe, pck, flt, kv;
  int bad_count, cmp_count, hp, hs, rep, lr;
  logic v1, v2, r1, r2;
  logic [9:0] p1, s1;
  logic kept;
  logic [17:0] ex;

  lvdsf_framer dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .master_clock_in(mck), .pixel_in(pix), .slave_pixel_in(spix),
    .row_valid(rv), .image_valid(iv), .stereo_mode(stm), .use_10bit(u10),
    .column_binning(bin), .serial_power_down(pd),
    .serial_data_power_down(dpd), .shift_clock_power_down(cpd),
    .stereo_error_in(err), .serial_data_pins(dout), .serial_data_oe(doe),
    .serial_shift_clock_pins(sck), .serial_shift_clock_oe(soe),
    .pixel_clock_out(pck), .stereo_fault_out(flt));

  lvdsf_rx rx (.clk(clk), .rst_n(rst_n), .serial_data_pins(dout),
    .serial_shift_clock_pins(sck), .column_binning(bin),
    .kept_word(kw), .kept_valid(kv));

  // Free running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({17'h0, got}, {17'h0, exp});
  endtask

  // Expected packet for the current mode
  function automatic logic [17:0] pk(int w, int s, logic r, logic v);
    logic [9:0] a;
    logic [9:0] c;
    a = 10'(w);
    c = 10'(s);
    if (stm) return {1'b0, c[9:2], a[9:2], 1'b1};
    if (u10) return {7'h0, a, 1'b1};
    return {7'h0, v, r, a[9:2], 1'b1};
  endfunction

  // One master clock period: drive a sample, then check the slot's word
  task automatic slot(input logic [9:0] a, b, input logic r, v);
    int w;
    int s;
    int f;
    pix = a;
    spix = b;
    rv = r;
    iv = v;
    mck = 1'b1;
    repeat (5) @(negedge clk);
    chk1(pck, 1'b0);
    chk1(sck, 1'b0);
    mck = 1'b0;
    kept = 1'b0;
    // Note any word the receiver keeps in this slot
    repeat (5) begin
      @(negedge clk);
      kept = kept | kv;
    end
    chk1(pck, 1'b1);
    chk1(sck, 1'b1);
    if (rep == 0) begin
      hp = p1;
      hs = s1;
    end
    w = (hp < 4) ? 4 : hp;
    s = (hs < 4) ? 4 : hs;
    f = (v && !v1) ? 0 : (v2 && !v1) ? 3 : (r && !r1) ? 1 : (r2 && !r1) ? 2 : -1;
    if (f >= 0) begin
      w = f;
      s = f;
    end
    ex = pk(w, s, r1, v1);
    chk(dout, ex);
    rep = r1 ? ((rep == lr) ? 0 : rep + 1) : 0;
    {v2, v1, r2, r1, p1, s1} = {v1, v, r1, r, a, b};
  endtask

  // Hang guard
  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    {rst_n, mck, rv, iv, stm, u10, pd, dpd, cpd, err} = 10'h000;
    {pix, spix, bin, hp, hs, rep, lr, bad_count, cmp_count} = 0;
    {v1, v2, r1, r2, p1, s1} = 0;
    void'($urandom(32'hc526d85e));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      {pd, dpd, cpd} = i[2:0];
      repeat (2) @(negedge clk);
      chk1(doe, !pd);
      chk1(soe, !(pd || cpd));
    end
    $display("power down test done");
    {pd, dpd, cpd} = 3'h0;
    for (int m = 0; m < 3; m++) begin
      for (int b = 0; b < 3; b++) begin
        stm = (m == 2);
        u10 = (m == 1);
        bin = 2'(b);
        lr = (b == 2) ? 3 : b;
        err = 1'($urandom);
        repeat (2) @(negedge clk);
        chk1(flt, stm && err);
        // Sixteen slots keep the receiver's undersampling phase aligned
        for (int j = 0; j < 16; j++) begin
          slot((j > 3 && j < 8) ? 10'(j - 4) : 10'($urandom), 10'($urandom),
            j > 3 && j < 10, j > 1 && j < 12);
          chk1(kept, j % (lr + 1) == 0);
          if (j % (lr + 1) == 0) begin
            chk({8'h0, kw}, {8'h0, ex[10:1]});
          end
        end
        $display("frame mode %0d binning %0d done", m, b);
      end
    end
    // Serial block left powered down once unused
    pd = 1'b1;
    repeat (2) @(negedge clk);
    chk1(doe, 1'b0);
    $display("final power down test done");
    report_and_stop;
  end
endmodule
